// file: wdog_params.svh
// Constants for the system watchdog: register map, fields, reset values and counts
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH

// Register byte offsets
`define WDOG_OFS_CTRL 8'h00
`define WDOG_OFS_RANGE 8'h04
`define WDOG_OFS_COUNT 8'h08
`define WDOG_OFS_RESTART 8'h0C
`define WDOG_OFS_STATUS 8'h10
`define WDOG_OFS_MASK 8'h14

// Control fields
`define WDOG_CTRL_EN_BIT 0
`define WDOG_CTRL_MODE_BIT 1
`define WDOG_CTRL_PLEN_LSB 2
`define WDOG_CTRL_PLEN_MSB 4
`define WDOG_RANGE_MSB 3

// Status and mask bits
`define WDOG_ST_TIMEOUT_BIT 0
`define WDOG_ST_RESET_BIT 1

// Reset values
`define WDOG_CTRL_RST 5'h00
`define WDOG_RANGE_RST 4'h0
`define WDOG_MASK_RST 2'h0

// Restart key; other values are ignored
`define WDOG_KICK_KEY 32'h00000076

// Log2 of the shortest timeout range in clock cycles
`define WDOG_RANGE_BASE_LOG2 16

// Shortest reset pulse in clock cycles; each step of the field doubles it
`define WDOG_PULSE_MIN_CYC 9'h002

`endif

// file: wdog_pkg.sv
// Types shared by the system watchdog modules
package wdog_pkg;
   typedef enum logic {
      RESP_DIRECT,
      RESP_TWO_STAGE
   } resp_mode_t;

   typedef enum logic [1:0] {
      PULSE_IDLE,
      PULSE_ACTIVE
   } pulse_state_t;

   typedef logic [2:0] pulse_sel_t;
   typedef logic [3:0] range_sel_t;
endpackage

// file: rst_pulse_if.sv
// Link between the watchdog core and its reset pulse generator
`timescale 1ns/10ps
interface rst_pulse_if;
   logic fire;
   wdog_pkg::pulse_sel_t len_sel;
   logic busy;
   logic rst_out_n;

   modport gen (
      input fire,
      input len_sel,
      output busy,
      output rst_out_n
   );

   modport ctl (
      output fire,
      output len_sel,
      input busy,
      input rst_out_n
   );
endinterface

// file: rst_pulse_gen.sv
// System reset pulse generator with a selectable pulse length
`timescale 1ns/10ps
`include "wdog_params.svh"
module rst_pulse_gen (
   input wire logic clk,
   input wire logic rst_n,
   rst_pulse_if.gen pif
);
   wdog_pkg::pulse_state_t state_ff;
   logic [8:0] len_cnt_ff;
   logic rst_out_n_ff;

   // Pulse lasts 2 << sel cycles
   function automatic logic [8:0] pulse_cycles(input wdog_pkg::pulse_sel_t sel);
      pulse_cycles = 9'(`WDOG_PULSE_MIN_CYC << sel);
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= wdog_pkg::PULSE_IDLE;
         len_cnt_ff <= 9'h000;
         rst_out_n_ff <= 1'b1;
      end else begin
         case (state_ff)
            wdog_pkg::PULSE_IDLE: begin
               // A fire request while a pulse runs is absorbed by it
               if (pif.fire) begin
                  state_ff <= wdog_pkg::PULSE_ACTIVE;
                  len_cnt_ff <= pulse_cycles(pif.len_sel) - 9'h001;
                  rst_out_n_ff <= 1'b0;
               end
            end
            wdog_pkg::PULSE_ACTIVE: begin
               if (len_cnt_ff == 9'h000) begin
                  state_ff <= wdog_pkg::PULSE_IDLE;
                  rst_out_n_ff <= 1'b1;
               end else begin
                  len_cnt_ff <= len_cnt_ff - 9'h001;
               end
            end
            default: begin
               state_ff <= wdog_pkg::PULSE_IDLE;
               rst_out_n_ff <= 1'b1;
            end
         endcase
      end
   end

   assign pif.busy = (state_ff == wdog_pkg::PULSE_ACTIVE);
   assign pif.rst_out_n = rst_out_n_ff;
endmodule

// file: system_watchdog.sv
// System watchdog: APB registers, down counter, response logic and interrupt
`timescale 1ns/10ps
`include "wdog_params.svh"
module system_watchdog #(
   parameter int RANGE_BASE_LOG2 = `WDOG_RANGE_BASE_LOG2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic sys_rst_n
);
   // Register state
   logic ctrl_en_ff;
   wdog_pkg::resp_mode_t mode_ff;
   wdog_pkg::pulse_sel_t plen_ff;
   wdog_pkg::range_sel_t range_ff;
   logic [31:0] count_ff;
   logic [1:0] status_ff;
   logic [1:0] mask_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic fire_ff;

   // Bus decode
   logic acc_phase;
   logic wr_take;
   logic rd_cap;
   logic addr_ok;
   logic kick;
   logic timeout;
   logic fire_now;
   logic [1:0] status_set;
   logic [1:0] status_clr;
   logic [1:0] nxt_status;

   rst_pulse_if pif ();

   rst_pulse_gen u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .pif(pif)
   );

   // Preset for a range: 2^(base+sel) - 1 so that a period spans 2^(base+sel) cycles
   function automatic logic [31:0] preset_of(input wdog_pkg::range_sel_t sel);
      logic [5:0] sh;
      sh = 6'(RANGE_BASE_LOG2) + {2'h0, sel};
      preset_of = (32'h00000001 << sh) - 32'h00000001;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         `WDOG_OFS_CTRL, `WDOG_OFS_RANGE, `WDOG_OFS_COUNT,
         `WDOG_OFS_RESTART, `WDOG_OFS_STATUS, `WDOG_OFS_MASK: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   assign acc_phase = psel && penable;
   // One wait state: the answer is given at the second access edge
   assign wr_take = acc_phase && pready_ff && pwrite && addr_ok;
   assign rd_cap = acc_phase && !pready_ff;
   assign addr_ok = is_mapped(paddr);
   assign kick = wr_take && (paddr == `WDOG_OFS_RESTART) && (pwdata == `WDOG_KICK_KEY);
   assign timeout = ctrl_en_ff && (count_ff == 32'h00000000);

   // Direct mode resets at once; two-stage resets when the first timeout is still pending
   always_comb begin
      fire_now = 1'b0;
      if (timeout) begin
         if (mode_ff == wdog_pkg::RESP_DIRECT) begin
            fire_now = 1'b1;
         end else if (status_ff[`WDOG_ST_TIMEOUT_BIT]) begin
            fire_now = 1'b1;
         end
      end
   end

   // APB handshake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc_phase && !pready_ff;
         pslverr_ff <= acc_phase && !pready_ff && !addr_ok;
      end
   end

   // Read data captured in the first access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h00000000;
      end else if (rd_cap && !pwrite) begin
         case (paddr)
            `WDOG_OFS_CTRL: prdata_ff <= {27'h0000000, plen_ff, mode_ff, ctrl_en_ff};
            `WDOG_OFS_RANGE: prdata_ff <= {28'h0000000, range_ff};
            `WDOG_OFS_COUNT: prdata_ff <= count_ff;
            `WDOG_OFS_STATUS: prdata_ff <= {30'h00000000, status_ff};
            `WDOG_OFS_MASK: prdata_ff <= {30'h00000000, mask_ff};
            default: prdata_ff <= 32'h00000000;
         endcase
      end else if (rd_cap) begin
         prdata_ff <= 32'h00000000;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_en_ff <= 1'(`WDOG_CTRL_RST >> `WDOG_CTRL_EN_BIT);
         mode_ff <= wdog_pkg::RESP_DIRECT;
         plen_ff <= 3'h0;
      end else if (wr_take && paddr == `WDOG_OFS_CTRL) begin
         ctrl_en_ff <= pwdata[`WDOG_CTRL_EN_BIT];
         mode_ff <= wdog_pkg::resp_mode_t'(pwdata[`WDOG_CTRL_MODE_BIT]);
         plen_ff <= pwdata[`WDOG_CTRL_PLEN_MSB:`WDOG_CTRL_PLEN_LSB];
      end
   end

   // Range select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         range_ff <= `WDOG_RANGE_RST;
      end else if (wr_take && paddr == `WDOG_OFS_RANGE) begin
         range_ff <= pwdata[`WDOG_RANGE_MSB:0];
      end
   end

   // Down counter on the bus clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= 32'hFFFFFFFF;
      end else if (!ctrl_en_ff || kick) begin
         count_ff <= preset_of(range_ff);
      end else if (timeout) begin
         count_ff <= preset_of(range_ff);
      end else begin
         count_ff <= count_ff - 32'h00000001;
      end
   end

   // Sticky status, write one to clear, set wins
   always_comb begin
      status_set = 2'h0;
      status_set[`WDOG_ST_TIMEOUT_BIT] = timeout;
      status_set[`WDOG_ST_RESET_BIT] = fire_now;
      status_clr = 2'h0;
      if (wr_take && paddr == `WDOG_OFS_STATUS) begin
         status_clr = pwdata[1:0];
      end
      nxt_status = (status_ff & ~status_clr) | status_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 2'h0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_ff <= `WDOG_MASK_RST;
      end else if (wr_take && paddr == `WDOG_OFS_MASK) begin
         mask_ff <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_status & mask_ff);
      end
   end

   // Reset request to the pulse generator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fire_ff <= 1'b0;
      end else begin
         fire_ff <= fire_now;
      end
   end

   assign pif.fire = fire_ff;
   assign pif.len_sel = plen_ff;

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign sys_rst_n = pif.rst_out_n;

   // Checking helpers: length of each reset pulse and the length expected for it
   logic [9:0] low_cnt_ff;
   logic [9:0] exp_len_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_ff <= 10'h000;
         exp_len_ff <= 10'h000;
      end else begin
         if (!pif.rst_out_n) begin
            low_cnt_ff <= low_cnt_ff + 10'h001;
         end else begin
            low_cnt_ff <= 10'h000;
         end
         if (pif.fire && !pif.busy) begin
            exp_len_ff <= 10'(10'h002 << plen_ff);
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_count_down;
      (ctrl_en_ff && !kick && count_ff != 32'h00000000)
         |=> (count_ff == $past(count_ff) - 32'h00000001);
   endproperty
   a_count_down: assert property (p_count_down) else $error("count did not step down");

   property p_timeout_zero;
      (ctrl_en_ff && !kick && count_ff == 32'h00000001
         && !(wr_take && paddr == `WDOG_OFS_CTRL)) |=> timeout;
   endproperty
   a_timeout_zero: assert property (p_timeout_zero) else $error("no timeout at zero");

   property p_reload;
      (timeout && !kick) |=> (count_ff == preset_of($past(range_ff)));
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_full_width;
      (!ctrl_en_ff && $past(rst_n)) |=> (count_ff == preset_of($past(range_ff)));
   endproperty
   a_full_width: assert property (p_full_width) else $error("counter lost high bits");

   property p_direct_reset;
      (timeout && mode_ff == wdog_pkg::RESP_DIRECT && !pif.busy && !fire_ff)
         |=> fire_ff ##1 !sys_rst_n;
   endproperty
   a_direct_reset: assert property (p_direct_reset) else $error("direct reset missing");

   property p_first_stage;
      (timeout && mode_ff == wdog_pkg::RESP_TWO_STAGE && !status_ff[0])
         |=> status_ff[0] && !fire_ff;
   endproperty
   a_first_stage: assert property (p_first_stage) else $error("first stage wrong");

   property p_second_stage;
      (timeout && mode_ff == wdog_pkg::RESP_TWO_STAGE && status_ff[0] && !pif.busy && !fire_ff)
         |-> ##[1:2] !sys_rst_n;
   endproperty
   a_second_stage: assert property (p_second_stage) else $error("second stage reset missing");

   property p_pulse_len;
      $rose(sys_rst_n) |-> (low_cnt_ff == exp_len_ff);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

   property p_range_write;
      (wr_take && paddr == `WDOG_OFS_RANGE) |=> (range_ff == $past(pwdata[3:0]));
   endproperty
   a_range_write: assert property (p_range_write) else $error("range select not stored");

   property p_irq_level;
      irq_ff == |(status_ff & $past(mask_ff));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

   property p_set_wins;
      (timeout && wr_take && paddr == `WDOG_OFS_STATUS && pwdata[0]) |=> status_ff[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("timeout flag lost on clear");

   property p_apb_answer;
      (acc_phase && !pready_ff) |=> pready_ff ##1 !pready_ff;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb ready timing wrong");

   property p_kick_reload;
      kick |=> (count_ff == preset_of($past(range_ff)));
   endproperty
   a_kick_reload: assert property (p_kick_reload) else $error("restart did not reload");

   property p_status_sticky;
      (status_ff[0] && !(wr_take && paddr == `WDOG_OFS_STATUS && pwdata[0]))
         |=> status_ff[0];
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("timeout flag dropped");

   property p_clear_one;
      (wr_take && paddr == `WDOG_OFS_STATUS && pwdata[0] && !timeout)
         |=> !status_ff[0];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("timeout flag not cleared");

   property p_fire_marks;
      fire_now |=> status_ff[`WDOG_ST_RESET_BIT];
   endproperty
   a_fire_marks: assert property (p_fire_marks) else $error("reset flag not set");

   property p_no_fire;
      !timeout |=> !fire_ff;
   endproperty
   a_no_fire: assert property (p_no_fire) else $error("reset request without timeout");

   property p_slverr;
      (acc_phase && !pready_ff && !addr_ok)
         |=> (pready_ff && pslverr_ff);
   endproperty
   a_slverr: assert property (p_slverr) else $error("no error for unmapped address");

   property p_rst_quiet;
      (!fire_ff && !pif.busy) |=> sys_rst_n;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("reset pulse without request");

   property p_read_count;
      (rd_cap && !pwrite && paddr == `WDOG_OFS_COUNT)
         |=> (prdata_ff == $past(count_ff));
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read wrong");

   property p_mask_write;
      (wr_take && paddr == `WDOG_OFS_MASK)
         |=> (mask_ff == $past(pwdata[1:0]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask not stored");
endmodule

// file: testbench.sv
// Self-checking testbench for the system watchdog over APB
`timescale 1ns/10ps
`include "wdog_params.svh"
module testbench;
   localparam int BASE = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic sys_rst_n;
   logic [31:0] rd;
   logic [31:0] c1;
   logic err;
   int errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int falls = 0;
   int t_rd = 0;
   int t1 = 0;
   int t2 = 0;
   int len = 0;
   int f = 0;

   system_watchdog #(.RANGE_BASE_LOG2(BASE)) dut (
      .clk(clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq),
      .sys_rst_n(sys_rst_n)
   );

   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(negedge sys_rst_n) falls = falls + 1;

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One transfer; answer taken at the rising edge where pready is high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge clk);
         n++;
      end
      chk1(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      t_rd = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk32(rd, exp);
   endtask

   task automatic wait_low(output int t);
      int n;
      n = 0;
      @(negedge clk);
      while (sys_rst_n !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      t = cyc;
      chk1(sys_rst_n, 1'b0);
   endtask

   task automatic pulse_len(output int l);
      l = 0;
      while (sys_rst_n === 1'b0 && l < 600) begin
         @(negedge clk);
         l++;
      end
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk1(irq, 1'b1);
   endtask

   initial begin
      #(25 * 60000);
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      test_done();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk1(sys_rst_n, 1'b1);
      rd_chk(`WDOG_OFS_CTRL, 32'h00000000);
      rd_chk(`WDOG_OFS_RANGE, 32'h00000000);
      rd_chk(`WDOG_OFS_MASK, 32'h00000000);
      rd_chk(`WDOG_OFS_STATUS, 32'h00000000);
      chk1(err, 1'b0);
      // Every range while disabled shows its full preset
      for (int r = 0; r < 16; r++) begin
         wr(`WDOG_OFS_RANGE, 32'(r));
         rd_chk(`WDOG_OFS_COUNT, 32'((64'h1 << (BASE + r)) - 64'h1));
      end
      wr(`WDOG_OFS_COUNT, 32'h12345678);
      rd_chk(`WDOG_OFS_COUNT, 32'((64'h1 << (BASE + 15)) - 64'h1));
      apb(1'b0, 8'h18, 32'h00000000);
      chk1(err, 1'b1);
      chk32(rd, 32'h00000000);
      // Direct response, range 5
      wr(`WDOG_OFS_RANGE, 32'h00000005);
      wr(`WDOG_OFS_CTRL, 32'h00000001);
      apb(1'b0, `WDOG_OFS_COUNT, 32'h00000000);
      c1 = rd;
      t1 = t_rd;
      apb(1'b0, `WDOG_OFS_COUNT, 32'h00000000);
      chk32(c1 - rd, 32'(t_rd - t1));
      for (int s = 0; s < 8; s++) begin
         wr(`WDOG_OFS_CTRL, 32'(1 | (s << 2)));
         wait_low(t1);
         pulse_len(len);
         chk32(32'(len), 32'(2 << s));
      end
      wait_low(t1);
      pulse_len(len);
      wait_low(t2);
      chk32(32'(t2 - t1), 32'(1 << (BASE + 5)));
      rd_chk(`WDOG_OFS_STATUS, 32'h00000003);
      // Two-stage response
      wr(`WDOG_OFS_CTRL, 32'h00000000);
      wr(`WDOG_OFS_STATUS, 32'h00000003);
      rd_chk(`WDOG_OFS_STATUS, 32'h00000000);
      wr(`WDOG_OFS_MASK, 32'h00000001);
      wr(`WDOG_OFS_CTRL, 32'h00000003);
      f = falls;
      wait_irq();
      chk32(32'(falls), 32'(f));
      rd_chk(`WDOG_OFS_STATUS, 32'h00000001);
      wr(`WDOG_OFS_MASK, 32'h00000000);
      rd_chk(`WDOG_OFS_MASK, 32'h00000000);
      chk1(irq, 1'b0);
      wr(`WDOG_OFS_MASK, 32'h00000001);
      wait_low(t1);
      chk32(32'(falls), 32'(f + 1));
      rd_chk(`WDOG_OFS_STATUS, 32'h00000003);
      // Serviced interrupts never lead to a reset
      wr(`WDOG_OFS_STATUS, 32'h00000003);
      f = falls;
      repeat (3) begin
         wait_irq();
         wr(`WDOG_OFS_STATUS, 32'h00000001);
      end
      chk32(32'(falls), 32'(f));
      // Restart with the key reloads; any other value is ignored
      wr(`WDOG_OFS_RESTART, `WDOG_KICK_KEY);
      rd_chk(`WDOG_OFS_COUNT, 32'((64'h1 << (BASE + 5)) - 64'h3));
      wr(`WDOG_OFS_RESTART, 32'h00000075);
      rd_chk(`WDOG_OFS_COUNT, 32'((64'h1 << (BASE + 5)) - 64'hB));
      test_done();
   end
endmodule
